/* logic/ides_map.vh */
// register offsets, field positions, reset values and timing counts of the input deserializer
`ifndef IDES_MAP_VH
`define IDES_MAP_VH

`define IDES_ADDR_W          4
`define IDES_OFF_CTRL        4'h0
`define IDES_OFF_STATUS      4'h4
`define IDES_OFF_WORD        4'h8

`define IDES_CTRL_WIDTH8     0
`define IDES_CTRL_DDR        1
`define IDES_CTRL_FIFO_EN    2
`define IDES_CTRL_SYNC_MODE  3
`define IDES_CTRL_FAST_INV   4
`define IDES_CTRL_CMPL_INV   5
`define IDES_CTRL_RST_INV    6
`define IDES_CTRL_RESET      7'h03

`define IDES_ST_EMPTY        0
`define IDES_ST_FULL         1
`define IDES_ST_OVERFLOW     2
`define IDES_ST_LEVEL_LSB    4

`define IDES_WORD_W          8
`define IDES_FIFO_DEPTH      8
`define IDES_FIFO_AW         3

// fast serial clock: period in ns and half period in clock cycles at 4 ns
`define IDES_MCLK_PERIOD_NS  4
`define IDES_FAST_PERIOD_NS  16
`define IDES_FAST_HALF_CYC   ((`IDES_FAST_PERIOD_NS / `IDES_MCLK_PERIOD_NS) / 2)

`endif

/* logic/ides_fifo.v */
// eight entry word fifo between the word strobe and the read strobe
`timescale 1ns/1ns
`include "ides_map.vh"

module ides_fifo (
	input  wire                      clk_i,
	input  wire                      rst_n_i,
	input  wire                      clr_i,
	input  wire                      push_i,
	input  wire [`IDES_WORD_W-1:0]   din_i,
	input  wire                      pop_i,
	output wire [`IDES_WORD_W-1:0]   dout_o,
	output wire                      empty_o,
	output wire                      full_o,
	output wire [`IDES_FIFO_AW:0]    level_o
);

	reg  [`IDES_WORD_W-1:0]  mem_reg [0:`IDES_FIFO_DEPTH-1];
	reg  [`IDES_FIFO_AW:0]   wr_ptr_reg;
	reg  [`IDES_FIFO_AW:0]   rd_ptr_reg;
	wire                     do_push;
	wire                     do_pop;
	integer                  i;

	assign empty_o = (wr_ptr_reg == rd_ptr_reg);
	assign full_o  = (wr_ptr_reg[`IDES_FIFO_AW-1:0] == rd_ptr_reg[`IDES_FIFO_AW-1:0]) &&
	                 (wr_ptr_reg[`IDES_FIFO_AW] != rd_ptr_reg[`IDES_FIFO_AW]);
	assign level_o = wr_ptr_reg - rd_ptr_reg;
	assign dout_o  = mem_reg[rd_ptr_reg[`IDES_FIFO_AW-1:0]];
	// a full fifo drops the incoming word rather than overwrite an unread one
	assign do_push = push_i && !full_o;
	assign do_pop  = pop_i && !empty_o;

	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr_reg <= {(`IDES_FIFO_AW+1){1'b0}};
			rd_ptr_reg <= {(`IDES_FIFO_AW+1){1'b0}};
			for (i = 0; i < `IDES_FIFO_DEPTH; i = i + 1) begin
				mem_reg[i] <= {`IDES_WORD_W{1'b0}};
			end
		end else if (clr_i) begin
			wr_ptr_reg <= {(`IDES_FIFO_AW+1){1'b0}};
			rd_ptr_reg <= {(`IDES_FIFO_AW+1){1'b0}};
		end else begin
			if (do_push) begin
				mem_reg[wr_ptr_reg[`IDES_FIFO_AW-1:0]] <= din_i;
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (do_pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end

endmodule // ides_fifo

/* logic/ides_top.v */
// serial-to-parallel input converter with optional word fifo
`timescale 1ns/1ns
`include "ides_map.vh"

module ides_top (
	input  wire                      MCLK_I,
	input  wire                      RESETN_I,
	input  wire [`IDES_ADDR_W-1:0]   ADDR_I,
	input  wire [31:0]               WDATA_I,
	input  wire                      WR_I,
	input  wire                      RD_I,
	output reg  [31:0]               RDATA_O,
	input  wire                      SER_D_I,
	input  wire                      RST_I,
	input  wire                      RD_CLK_I,
	input  wire                      RD_EN_I,
	output reg  [`IDES_WORD_W-1:0]   Q_O,
	output reg                       EMPTY_O,
	output reg                       WORD_STB_O
);

	localparam [7:0] HALF_CYC = `IDES_FAST_HALF_CYC;

	reg  [1:0]               rst_sync_reg;
	wire                     rst_n;
	reg  [2:0]               d_sync_reg;
	reg  [2:0]               r_sync_reg;
	reg  [2:0]               ck_sync_reg;
	reg  [2:0]               en_sync_reg;
	reg                      d_stable_reg;
	reg                      r_stable_reg;
	reg                      ck_stable_reg;
	reg                      en_stable_reg;
	reg                      ck_prev_reg;
	reg  [6:0]               ctrl_reg;
	reg                      overflow_reg;
	reg  [7:0]               phase_reg;
	reg                      fast_lvl_reg;
	reg  [`IDES_WORD_W-1:0]  shift_reg;
	reg  [3:0]               count_reg;
	reg  [`IDES_WORD_W-1:0]  word_reg;
	reg  [`IDES_WORD_W-1:0]  shift_next;
	reg  [3:0]               count_next;
	reg                      word_done;
	wire                     width8;
	wire                     ddr;
	wire                     fifo_en;
	wire                     blk_rst;
	wire                     half_tick;
	wire                     rise_en;
	wire                     fall_en;
	wire                     cap_en;
	wire                     rd_edge;
	wire                     pop;
	wire [3:0]               width_pos;
	wire [`IDES_WORD_W-1:0]  fifo_dout;
	wire                     fifo_empty;
	wire                     fifo_full;
	wire [`IDES_FIFO_AW:0]   fifo_level;

	assign rst_n   = rst_sync_reg[1];
	assign width8  = ctrl_reg[`IDES_CTRL_WIDTH8];
	assign ddr     = ctrl_reg[`IDES_CTRL_DDR];
	assign fifo_en = ctrl_reg[`IDES_CTRL_FIFO_EN];
	assign blk_rst = r_stable_reg ^ ctrl_reg[`IDES_CTRL_RST_INV];
	assign width_pos = width8 ? 4'h8 : 4'h4;

	always @(posedge MCLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end

	// pins cross in through three flops; a level counts once stages two and three agree
	always @(posedge MCLK_I or negedge rst_n) begin
		if (!rst_n) begin
			d_sync_reg    <= 3'h0;
			r_sync_reg    <= 3'h0;
			ck_sync_reg   <= 3'h0;
			en_sync_reg   <= 3'h0;
			d_stable_reg  <= 1'b0;
			r_stable_reg  <= 1'b0;
			ck_stable_reg <= 1'b0;
			en_stable_reg <= 1'b0;
			ck_prev_reg   <= 1'b0;
		end else begin
			d_sync_reg  <= {d_sync_reg[1:0], SER_D_I};
			r_sync_reg  <= {r_sync_reg[1:0], RST_I};
			ck_sync_reg <= {ck_sync_reg[1:0], RD_CLK_I};
			en_sync_reg <= {en_sync_reg[1:0], RD_EN_I};
			if (d_sync_reg[1] == d_sync_reg[2]) begin
				d_stable_reg <= d_sync_reg[2];
			end
			if (r_sync_reg[1] == r_sync_reg[2]) begin
				r_stable_reg <= r_sync_reg[2];
			end
			if (ck_sync_reg[1] == ck_sync_reg[2]) begin
				ck_stable_reg <= ck_sync_reg[2];
			end
			if (en_sync_reg[1] == en_sync_reg[2]) begin
				en_stable_reg <= en_sync_reg[2];
			end
			ck_prev_reg <= ck_stable_reg;
		end
	end

	// fast clock is an internal divider; each half period gives one enable pulse
	assign half_tick = (phase_reg == HALF_CYC - 8'h01);
	// fast clock inversion swaps which half is the rising edge
	assign rise_en = half_tick && (fast_lvl_reg == ctrl_reg[`IDES_CTRL_FAST_INV]);
	// complement edge is the opposite half whether inverted locally or not
	assign fall_en = half_tick && (fast_lvl_reg != ctrl_reg[`IDES_CTRL_FAST_INV]);
	// capture on fast edge, plus complement edge in double rate
	assign cap_en  = rise_en || (ddr && fall_en);

	always @(posedge MCLK_I or negedge rst_n) begin
		if (!rst_n) begin
			phase_reg    <= 8'h00;
			fast_lvl_reg <= 1'b0;
		end else if (half_tick) begin
			phase_reg    <= 8'h00;
			fast_lvl_reg <= ~fast_lvl_reg;
		end else begin
			phase_reg <= phase_reg + 8'h01;
		end
	end

	always @* begin
		shift_next = shift_reg;
		count_next = count_reg;
		word_done  = 1'b0;
		if (cap_en) begin
			if (ddr) begin
				// new bits enter at the top, so the first one ends at bit 0
				if (width8) begin
					shift_next = {d_stable_reg, shift_reg[7:1]};
				end else begin
					shift_next = {4'h0, d_stable_reg, shift_reg[3:1]};
				end
				count_next = count_reg + 4'h1;
			end else begin
				// single rate fills two positions per bit, both carry the same data
				if (width8) begin
					shift_next = {d_stable_reg, d_stable_reg, shift_reg[7:2]};
				end else begin
					shift_next = {4'h0, d_stable_reg, d_stable_reg, shift_reg[3:2]};
				end
				count_next = count_reg + 4'h2;
			end
			// ratio follows width and rate: 8 or 4 positions per word
			if (count_next >= width_pos) begin
				count_next = 4'h0;
				word_done  = 1'b1;
			end
		end
	end

	always @(posedge MCLK_I or negedge rst_n) begin
		if (!rst_n) begin
			shift_reg  <= {`IDES_WORD_W{1'b0}};
			count_reg  <= 4'h0;
			word_reg   <= {`IDES_WORD_W{1'b0}};
			WORD_STB_O <= 1'b0;
		end else if (blk_rst) begin
			shift_reg  <= {`IDES_WORD_W{1'b0}};
			count_reg  <= 4'h0;
			word_reg   <= {`IDES_WORD_W{1'b0}};
			WORD_STB_O <= 1'b0;
		end else begin
			shift_reg  <= shift_next;
			count_reg  <= count_next;
			WORD_STB_O <= word_done;
			// width 4 keeps bits 7..4 at zero
			if (word_done) begin
				word_reg <= shift_next;
			end
		end
	end

	// read clock pin edge; reading happens only on the reader's own rising edge
	assign rd_edge = ck_stable_reg && !ck_prev_reg;
	// read enable gates every read, empty blocks it
	assign pop = fifo_en && rd_edge && en_stable_reg && !fifo_empty;

	// eight entry fifo fed by each completed word
	ides_fifo u_fifo (
		.clk_i   (MCLK_I),
		.rst_n_i (rst_n),
		.clr_i   (blk_rst || !fifo_en),
		.push_i  (fifo_en && WORD_STB_O),
		.din_i   (word_reg),
		.pop_i   (pop),
		.dout_o  (fifo_dout),
		.empty_o (fifo_empty),
		.full_o  (fifo_full),
		.level_o (fifo_level)
	);

	always @(posedge MCLK_I or negedge rst_n) begin
		if (!rst_n) begin
			Q_O     <= {`IDES_WORD_W{1'b0}};
			EMPTY_O <= 1'b1;
		end else begin
			EMPTY_O <= fifo_empty || !fifo_en;
			if (fifo_en) begin
				// Q_O moves only on a read clock edge
				// a word pushed into an empty fifo in the cycle of a read edge waits for the next one
				if (pop) begin
					Q_O <= fifo_dout;
				end
			end else if (WORD_STB_O) begin
				// bypass follows the slow word strobe
				Q_O <= word_reg;
			end
		end
	end

	// register port: writes steer the block, reads show its state
	always @(posedge MCLK_I or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg     <= `IDES_CTRL_RESET;
			overflow_reg <= 1'b0;
			RDATA_O      <= 32'h00000000;
		end else begin
			if (WR_I && ADDR_I == `IDES_OFF_CTRL) begin
				ctrl_reg <= WDATA_I[6:0];
			end
			// set wins over a write-one clear in the same cycle
			if (fifo_en && WORD_STB_O && fifo_full) begin
				overflow_reg <= 1'b1;
			end else if (WR_I && ADDR_I == `IDES_OFF_STATUS && WDATA_I[`IDES_ST_OVERFLOW]) begin
				overflow_reg <= 1'b0;
			end
			RDATA_O <= 32'h00000000;
			if (RD_I) begin
				case (ADDR_I)
					`IDES_OFF_CTRL: begin
						RDATA_O <= {25'h0000000, ctrl_reg};
					end
					`IDES_OFF_STATUS: begin
						// level takes bits 7..4 so the word stays exactly 32 bits wide
						RDATA_O <= {24'h000000, fifo_level, 1'b0, overflow_reg,
							fifo_full, fifo_empty};
					end
					`IDES_OFF_WORD: begin
						RDATA_O <= {24'h000000, word_reg};
					end
					default: begin
						RDATA_O <= 32'h00000000;
					end
				endcase
			end
		end
	end

endmodule // ides_top

/* testbench/ides_top_checker.sv */
// assertions on the deserializer top ports
`timescale 1ns/1ns
`include "ides_map.vh"
module ides_top_checker (
	input wire                    MCLK_I,
	input wire                    RESETN_I,
	input wire [`IDES_ADDR_W-1:0] ADDR_I,
	input wire [31:0]             WDATA_I,
	input wire                    WR_I,
	input wire                    RD_I,
	input wire [31:0]             RDATA_O,
	input wire [`IDES_WORD_W-1:0] Q_O,
	input wire                    EMPTY_O,
	input wire                    WORD_STB_O
);
	reg  [6:0] ctrl_reg;
	wire       fifo_on = ctrl_reg[`IDES_CTRL_FIFO_EN];
	always @(posedge MCLK_I or negedge RESETN_I)
		if (!RESETN_I)
			ctrl_reg <= `IDES_CTRL_RESET;
		else if (WR_I && ADDR_I == `IDES_OFF_CTRL)
			ctrl_reg <= WDATA_I[6:0];
	default clocking cb @(posedge MCLK_I);
	endclocking
	default disable iff (!RESETN_I);
	sequence fifo_off3;
		!fifo_on [*3];
	endsequence
	sequence sdr_word;
		WORD_STB_O && !fifo_on && !ctrl_reg[`IDES_CTRL_DDR];
	endsequence
	rdata_idle_a:
	assert property (!$past(RD_I) |-> RDATA_O == 32'h0) else $error("read data not idle");
	ctrl_read_a:
	assert property (RD_I && ADDR_I == `IDES_OFF_CTRL |=> RDATA_O == {25'h0, ctrl_reg})
		else $error("control readback differs");
	unmapped_read_a:
	assert property (RD_I && ADDR_I != 4'h0 && ADDR_I != 4'h4 && ADDR_I != 4'h8
		|=> RDATA_O == 32'h0) else $error("unmapped read not zero");
	stb_gap_a:
	assert property (WORD_STB_O |=> !WORD_STB_O [*7]) else $error("words too close");
	bypass_q_a:
	assert property (!fifo_on && !$past(fifo_on) && $changed(Q_O) |-> $past(WORD_STB_O))
		else $error("bypass word moved without strobe");
	empty_bypass_a:
	assert property (fifo_off3 |-> EMPTY_O) else $error("empty low in bypass");
	narrow_word_a:
	assert property (WORD_STB_O && !fifo_on && !ctrl_reg[`IDES_CTRL_WIDTH8]
		|=> Q_O[7:4] == 4'h0) else $error("narrow word upper bits set");
	sdr_pairs_a:
	assert property (sdr_word |=> Q_O[1] == Q_O[0] && Q_O[3] == Q_O[2] && Q_O[5] == Q_O[4]
		&& Q_O[7] == Q_O[6]) else $error("single rate pair differs");
	pop_nonempty_a:
	assert property (fifo_on && $past(fifo_on) && $changed(Q_O) |-> !$past(EMPTY_O))
		else $error("word popped from empty fifo");
endmodule // ides_top_checker

/* testbench/ides_link_model.sv */
// serial transmitter and fifo reader facing the deserializer
`timescale 1ns/1ns
module ides_link_model (
	input  wire       clk_i,
	input  wire       ddr_i,
	input  wire [1:0] pat_i,
	input  wire       rd_run_i,
	input  wire       rd_slow_i,
	input  wire       rd_go_i,
	input  wire       empty_i,
	output reg        ser_o,
	output reg        rd_clk_o,
	output wire       rd_en_o
);
	reg [3:0]  tick;
	reg [31:0] rnd;
	initial begin
		tick = 4'h0;
		ser_o = 1'b0;
		rd_clk_o = 1'b0;
	end
	always @(posedge clk_i) begin
		tick <= tick + 4'h1;
		rnd <= $urandom;
		// one bit per fast period, two in double rate
		// both fast edges come from one clock, so bits may change on either half
		if ((ddr_i && tick[0]) || tick[1:0] == 2'h3)
			ser_o <= (pat_i == 2'h2) ? rnd[0] : pat_i[0];
		// idle reader holds its clock low; slow reader lets words pile up
		if (!rd_run_i)
			rd_clk_o <= 1'b0;
		else if (rd_slow_i ? tick == 4'hF : tick[0])
			rd_clk_o <= ~rd_clk_o;
	end
	// read enable is the inverse of empty, low when idle
	assign rd_en_o = rd_go_i & ~empty_i;
endmodule // ides_link_model

/* testbench/input_deserializer_fifo_bench.sv */
// randomized bench for the input deserializer and its link partner
`timescale 1ns/1ns
`include "ides_map.vh"
module input_deserializer_fifo_bench;
	reg        clk, resetn, wr, rd, rst, rd_run, rd_slow, rd_go;
	reg [3:0]  addr;
	reg [31:0] wdata, d;
	reg [1:0]  pat;
	reg [7:0]  ctl, w;
	wire [31:0] rdata;
	wire [7:0]  q;
	wire        empty, stb, ser, rd_clk, rd_en;
	integer     errors, n_checks, i, k, m;
	initial clk = 1'b0;
	always #2 clk = ~clk;
	ides_top u_ides_top (.MCLK_I(clk), .RESETN_I(resetn), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .SER_D_I(ser), .RST_I(rst), .RD_CLK_I(rd_clk),
		.RD_EN_I(rd_en), .Q_O(q), .EMPTY_O(empty), .WORD_STB_O(stb));
	ides_link_model u_ides_link_model (.clk_i(clk), .ddr_i(ctl[1]), .pat_i(pat),
		.rd_run_i(rd_run), .rd_slow_i(rd_slow), .rd_go_i(rd_go), .empty_i(empty),
		.ser_o(ser), .rd_clk_o(rd_clk), .rd_en_o(rd_en));
	task check(input [31:0] seen, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (seen !== exp) begin
				errors = errors + 1;
				$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task final_report;
		begin
			$display("checks %0d mismatches %0d", n_checks, errors);
			if (errors == 0 && n_checks > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	task bus(input r, input [3:0] a, input [31:0] v);
		begin
			@(posedge clk);
			addr <= a;
			wdata <= v;
			rd <= r;
			wr <= ~r;
			@(posedge clk);
			rd <= 1'b0;
			wr <= 1'b0;
			#1 d = rdata;
		end
	endtask
	// bounded wait on the word strobe, then take the word a cycle later
	task wait_word;
		begin
			for (i = 0; i < 300 && stb !== 1'b1; i = i + 1)
				@(posedge clk) #1;
			check(i < 300, 1);
			if (i >= 300)
				final_report;
			@(posedge clk) #1 w = q;
		end
	endtask
	// reconfigure under block reset so no word mixes two modes
	// the sync mode bit is never set by any configuration
	task cfg(input [7:0] c);
		begin
			rst <= 1'b1;
			repeat (8) @(posedge clk);
			ctl <= c;
			bus(0, `IDES_OFF_CTRL, {24'h0, c});
			repeat (8) @(posedge clk);
			rst <= 1'b0;
		end
	endtask
	// earliest bit lowest: a zero-to-one step leaves ones only at the top
	function order_ok(input [7:0] v, input wide);
		reg [7:0] z;
		begin
			z = ~v & (wide ? 8'hFF : 8'h0F);
			order_ok = (z & (z + 8'h01)) == 8'h00;
		end
	endfunction
	initial begin
		{errors, n_checks, m} = 0;
		{resetn, addr, wdata, wr, rd, rst, rd_run, rd_slow, rd_go} = 0;
		ctl = 8'h03;
		pat = 2'h1;
		d = $urandom(51764);
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		bus(1, `IDES_OFF_CTRL, 0);
		check(d, 32'h3);
		bus(1, `IDES_OFF_STATUS, 0);
		check(d, 32'h1);
		bus(0, 4'hC, $urandom);
		bus(1, 4'hC, 0);
		check(d, 32'h0);
		$display("registers done");
		for (m = 3; m >= 0; m = m - 1) begin
			cfg(m[7:0]);
			pat <= 2'h2;
			repeat (3) wait_word;
			pat <= 2'h0;
			repeat (3) wait_word;
			pat <= 2'h1;
			for (k = 0; k < 5 && w == 8'h00; k = k + 1)
				wait_word;
			check(order_ok(w, m[0]), 1);
			wait_word;
			check(w, m[0] ? 8'hFF : 8'h0F);
			bus(1, `IDES_OFF_WORD, 0);
			check(d, {24'h0, w});
			check(empty, 1);
			$display("mode %0d done", m);
		end
		cfg(8'h07);
		rd_run <= 1'b1;
		repeat (200) @(posedge clk);
		bus(1, `IDES_OFF_STATUS, 0);
		check(d, 32'h86);
		check(empty, 0);
		rd_go <= 1'b1;
		for (i = 0; i < 300 && empty !== 1'b1; i = i + 1)
			@(posedge clk) #1;
		check(empty, 1);
		if (i >= 300)
			final_report;
		check(q, 8'hFF);
		bus(0, `IDES_OFF_STATUS, 32'h4);
		bus(1, `IDES_OFF_STATUS, 0);
		check(d & 32'h4, 0);
		rd_slow <= 1'b1;
		repeat (200) @(posedge clk);
		check(empty, 0);
		rd_go <= 1'b0;
		rd_run <= 1'b0;
		$display("fifo done");
		cfg(8'h03);
		bus(0, `IDES_OFF_CTRL, 32'h43);
		repeat (8) @(posedge clk);
		k = 0;
		repeat (40) @(posedge clk) #1 k = k + stb;
		check(k, 0);
		rst <= 1'b1;
		wait_word;
		check(w, 8'hFF);
		bus(0, `IDES_OFF_CTRL, 32'h03);
		rst <= 1'b0;
		$display("reset invert done");
		final_report;
	end
endmodule // input_deserializer_fifo_bench
bind ides_top ides_top_checker u_ides_top_checker (.MCLK_I(MCLK_I), .RESETN_I(RESETN_I),
	.ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
	.Q_O(Q_O), .EMPTY_O(EMPTY_O), .WORD_STB_O(WORD_STB_O));
